/* src/cc_gen_pkg.sv */
// types and constants shared by the condition-code generator
package cc_gen_pkg;

  localparam int DATA_W = 16;
  localparam int ARITH_W = 18;

  // apb register byte offsets
  localparam logic [7:0] OFFS_FLAGS = 8'h00;
  localparam logic [7:0] OFFS_SUM   = 8'h04;

  // field positions inside the flag register
  localparam int POS_LOW  = 0;
  localparam int POS_HIGH = 1;
  localparam int POS_OVF  = 2;
  localparam int POS_LRB  = 3;

  // reset values
  localparam logic [15:0] RST_SUM = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // arithmetic range limits
  localparam logic signed [17:0] ARITH_MIN  = -18'sd32768;
  localparam logic signed [17:0] ARITH_MAX  = 18'sd32767;
  localparam logic signed [17:0] ARITH_WRAP = -18'sd65536;
  localparam logic [15:0] MOST_NEG = 16'h8000;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_COMPARE = 3'h1,
    OP_ARITH   = 3'h2,
    OP_LOGIC   = 3'h3,
    OP_SHIFT   = 3'h4,
    OP_CONVERT = 3'h5,
    OP_CONSTADD = 3'h6
  } op_class_t;

  typedef enum logic [2:0] {
    REL_EQ = 3'h0,
    REL_NE = 3'h1,
    REL_GT = 3'h2,
    REL_GE = 3'h3,
    REL_LT = 3'h4,
    REL_LE = 3'h5
  } cmp_rel_t;

  typedef struct packed {
    op_class_t            opClass;
    cmp_rel_t             cmpRel;
    logic [15:0]          firstAccumulator;
    logic [15:0]          secondAccumulator;
    logic signed [17:0]   arithResult;
    logic [15:0]          logicResult;
    logic                 shiftOutBit;
    logic [15:0]          constValue;
  } op_req_t;

  typedef struct packed {
    logic logicResultBit;
    logic overflowCode;
    logic statusCodeHigh;
    logic statusCodeLow;
  } flags_t;

  typedef struct packed {
    logic jumpOnZero;
    logic jumpOnNonzero;
    logic jumpOnPlus;
    logic jumpOnMinus;
    logic jumpOnOverflow;
    logic jumpOnLogicResult;
  } jumps_t;

  typedef struct packed {
    flags_t      flags;
    logic [15:0] sum;
    logic [31:0] rdata;
    logic        slvErr;
  } state_t;

endpackage

/* src/condition_code_generator.sv */
// condition-code generator with apb access to its flags
`timescale 1ns/1ps

// Overview of operation
// - three condition flags, low, high and overflow, feed jump logic.
// - a comparison updates low and high and keeps overflow.
// - second vs first accumulator gives equal 00, less 01, greater 10.
// - a comparison writes the logic result bit, 1 when it holds.
// - a fixed-point arithmetic operation updates all three flags.
// - arithmetic result ranges map to fixed high, low, overflow codes.
// - an arithmetic result of -65536 gives high 0, low 0, overflow 1.
// - a word logic operation updates low and high and keeps overflow.
// - after word logic a zero result gives 00 and nonzero gives 10.
// - a shift updates low and high and keeps overflow.
// - the last bit shifted out gives 00 for 0 and 10 for 1.
// - two's-complement conversion updates all three flags.
// - conversion of 8000h gives 011, else the result sign decides.
// - jump conditions are decoded from the flags as zero, nonzero etc.
// - constant add keeps flags and logic bit and wraps at 16 bits.
module condition_code_generator (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 opValid,
  input  wire cc_gen_pkg::op_req_t  opReq,
  output cc_gen_pkg::flags_t        flagsOut,
  output cc_gen_pkg::jumps_t        jumpsOut,
  output logic [15:0]               constSum,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr
);

  cc_gen_pkg::state_t state_q;
  cc_gen_pkg::state_t state_d;

  // {high, low, ovf} for a signed arithmetic result
  function automatic logic [2:0] arithCodes(logic signed [17:0] r);
    if (r == cc_gen_pkg::ARITH_WRAP) begin
      arithCodes = 3'b001;
    end else if (r < cc_gen_pkg::ARITH_MIN) begin
      arithCodes = 3'b101;
    end else if (r < 18'sd0) begin
      arithCodes = 3'b010;
    end else if (r == 18'sd0) begin
      arithCodes = 3'b000;
    end else if (r <= cc_gen_pkg::ARITH_MAX) begin
      arithCodes = 3'b100;
    end else begin
      arithCodes = 3'b011;
    end
  endfunction

  // {high, low, ovf} for a two's-complement conversion of x
  function automatic logic [2:0] convCodes(logic [15:0] x);
    logic [15:0] neg;
    neg = 16'h0000 - x;
    if (x == cc_gen_pkg::MOST_NEG) begin
      convCodes = 3'b011;
    end else if (neg[15]) begin
      convCodes = 3'b010;
    end else if (neg == 16'h0000) begin
      convCodes = 3'b000;
    end else begin
      convCodes = 3'b100;
    end
  endfunction

  function automatic logic [1:0] zeroOrPlus(logic nonzero);
    zeroOrPlus = nonzero ? 2'b10 : 2'b00;
  endfunction

  logic signed [16:0] acc1S;
  logic signed [16:0] acc2S;
  logic               cmpLess;
  logic               cmpEqual;
  logic               cmpHolds;
  logic [2:0]         codes3;
  logic               apbAccess;
  logic               apbSetup;
  logic               addrOk;

  always_comb begin
    acc1S = {opReq.firstAccumulator[15], opReq.firstAccumulator};
    acc2S = {opReq.secondAccumulator[15], opReq.secondAccumulator};
    cmpLess = acc2S < acc1S;
    cmpEqual = acc2S == acc1S;
    unique case (opReq.cmpRel)
      cc_gen_pkg::REL_EQ: cmpHolds = cmpEqual;
      cc_gen_pkg::REL_NE: cmpHolds = !cmpEqual;
      cc_gen_pkg::REL_GT: cmpHolds = !cmpLess && !cmpEqual;
      cc_gen_pkg::REL_GE: cmpHolds = !cmpLess;
      cc_gen_pkg::REL_LT: cmpHolds = cmpLess;
      cc_gen_pkg::REL_LE: cmpHolds = cmpLess || cmpEqual;
      default:            cmpHolds = 1'b0;
    endcase
  end

  assign apbSetup = psel && !penable;
  assign apbAccess = psel && penable;
  assign addrOk = (paddr == cc_gen_pkg::OFFS_FLAGS) ||
                  (paddr == cc_gen_pkg::OFFS_SUM);

  always_comb begin
    state_d = state_q;
    codes3 = 3'b000;
    // software restore of flags first, so a same-cycle operation wins on the flags it updates
    if (apbAccess && pwrite && paddr == cc_gen_pkg::OFFS_FLAGS) begin
      state_d.flags.statusCodeLow  = pwdata[cc_gen_pkg::POS_LOW];
      state_d.flags.statusCodeHigh = pwdata[cc_gen_pkg::POS_HIGH];
      state_d.flags.overflowCode   = pwdata[cc_gen_pkg::POS_OVF];
      state_d.flags.logicResultBit = pwdata[cc_gen_pkg::POS_LRB];
    end
    if (opValid) begin
      unique case (opReq.opClass)
        cc_gen_pkg::OP_COMPARE: begin
          state_d.flags.statusCodeHigh = !cmpLess && !cmpEqual;
          state_d.flags.statusCodeLow  = cmpLess;
          state_d.flags.logicResultBit = cmpHolds;
        end
        cc_gen_pkg::OP_ARITH: begin
          codes3 = arithCodes(opReq.arithResult);
          {state_d.flags.statusCodeHigh, state_d.flags.statusCodeLow,
           state_d.flags.overflowCode} = codes3;
        end
        cc_gen_pkg::OP_LOGIC: begin
          {state_d.flags.statusCodeHigh, state_d.flags.statusCodeLow} =
            zeroOrPlus(|opReq.logicResult);
        end
        cc_gen_pkg::OP_SHIFT: begin
          {state_d.flags.statusCodeHigh, state_d.flags.statusCodeLow} =
            zeroOrPlus(opReq.shiftOutBit);
        end
        cc_gen_pkg::OP_CONVERT: begin
          codes3 = convCodes(opReq.firstAccumulator);
          {state_d.flags.statusCodeHigh, state_d.flags.statusCodeLow,
           state_d.flags.overflowCode} = codes3;
        end
        cc_gen_pkg::OP_CONSTADD: begin
          // carry is dropped, nothing spills into the second accumulator
          state_d.sum =
            16'(opReq.firstAccumulator + opReq.constValue);
        end
        default: begin
          // other classes leave every flag as it is
          state_d.sum = state_q.sum;
        end
      endcase
    end
    // read data is captured in setup so the access phase has no wait state
    if (apbSetup) begin
      state_d.slvErr = !addrOk;
      state_d.rdata = cc_gen_pkg::RST_RDATA;
      if (!pwrite && paddr == cc_gen_pkg::OFFS_FLAGS) begin
        state_d.rdata[cc_gen_pkg::POS_LOW]  = state_q.flags.statusCodeLow;
        state_d.rdata[cc_gen_pkg::POS_HIGH] = state_q.flags.statusCodeHigh;
        state_d.rdata[cc_gen_pkg::POS_OVF]  = state_q.flags.overflowCode;
        state_d.rdata[cc_gen_pkg::POS_LRB]  = state_q.flags.logicResultBit;
      end else if (!pwrite && paddr == cc_gen_pkg::OFFS_SUM) begin
        state_d.rdata[15:0] = state_q.sum;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q.flags <= '0;
      state_q.sum <= cc_gen_pkg::RST_SUM;
      state_q.rdata <= cc_gen_pkg::RST_RDATA;
      state_q.slvErr <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flagsOut = state_q.flags;
  assign constSum = state_q.sum;
  assign prdata = state_q.rdata;
  assign pready = apbAccess;
  assign pslverr = apbAccess && state_q.slvErr;

  always_comb begin
    jumpsOut.jumpOnZero = !state_q.flags.statusCodeHigh &&
                          !state_q.flags.statusCodeLow;
    jumpsOut.jumpOnNonzero = state_q.flags.statusCodeHigh ||
                             state_q.flags.statusCodeLow;
    jumpsOut.jumpOnPlus = state_q.flags.statusCodeHigh &&
                          !state_q.flags.statusCodeLow;
    jumpsOut.jumpOnMinus = !state_q.flags.statusCodeHigh &&
                           state_q.flags.statusCodeLow;
    jumpsOut.jumpOnOverflow = state_q.flags.overflowCode;
    jumpsOut.jumpOnLogicResult = state_q.flags.logicResultBit;
  end

  logic opCmp;
  logic opArith;
  logic opConv;
  logic opAdd;
  assign opCmp = opValid && opReq.opClass == cc_gen_pkg::OP_COMPARE;
  assign opArith = opValid && opReq.opClass == cc_gen_pkg::OP_ARITH;
  assign opConv = opValid && opReq.opClass == cc_gen_pkg::OP_CONVERT;
  assign opAdd = opValid && opReq.opClass == cc_gen_pkg::OP_CONSTADD;
  logic opLogic;
  logic opShift;
  assign opLogic = opValid && opReq.opClass == cc_gen_pkg::OP_LOGIC;
  assign opShift = opValid && opReq.opClass == cc_gen_pkg::OP_SHIFT;

  AST_CMP_KEEPS_OVF:
  assert property (@(posedge core_clk) disable iff (rst)
    opCmp && !(apbAccess && pwrite) |=>
      flagsOut.overflowCode == $past(flagsOut.overflowCode))
    else $error("compare changed overflow code");

  AST_CMP_LESS:
  assert property (@(posedge core_clk) disable iff (rst)
    opCmp && $signed(opReq.secondAccumulator) <
             $signed(opReq.firstAccumulator) |=>
      !flagsOut.statusCodeHigh && flagsOut.statusCodeLow &&
      jumpsOut.jumpOnMinus)
    else $error("compare less-than codes wrong");

  AST_CMP_EQ_LRB:
  assert property (@(posedge core_clk) disable iff (rst)
    opCmp && opReq.cmpRel == cc_gen_pkg::REL_EQ |=>
      flagsOut.logicResultBit ==
        ($past(opReq.firstAccumulator) == $past(opReq.secondAccumulator)))
    else $error("logic result bit wrong after equality compare");

  AST_ARITH_NEG_OVF:
  assert property (@(posedge core_clk) disable iff (rst)
    opArith && opReq.arithResult < -18'sd32768 &&
    opReq.arithResult != -18'sd65536 |=>
      flagsOut.statusCodeHigh && !flagsOut.statusCodeLow &&
      flagsOut.overflowCode)
    else $error("negative overflow codes wrong");

  AST_ARITH_POS_OVF:
  assert property (@(posedge core_clk) disable iff (rst)
    opArith && opReq.arithResult > 18'sd32767 |=>
      jumpsOut.jumpOnMinus && jumpsOut.jumpOnOverflow)
    else $error("positive overflow codes wrong");

  AST_ARITH_WRAP:
  assert property (@(posedge core_clk) disable iff (rst)
    opArith && opReq.arithResult == -18'sd65536 |=>
      jumpsOut.jumpOnZero && jumpsOut.jumpOnOverflow)
    else $error("minus 65536 codes wrong");

  AST_CONV_MOST_NEG:
  assert property (@(posedge core_clk) disable iff (rst)
    opConv && opReq.firstAccumulator == 16'h8000 |=>
      {flagsOut.statusCodeHigh, flagsOut.statusCodeLow,
       flagsOut.overflowCode} == 3'b011)
    else $error("conversion of 8000h codes wrong");

  AST_CONV_POS:
  assert property (@(posedge core_clk) disable iff (rst)
    opConv && opReq.firstAccumulator[15] &&
    opReq.firstAccumulator != 16'h8000 |=>
      jumpsOut.jumpOnPlus && !jumpsOut.jumpOnOverflow)
    else $error("conversion to positive codes wrong");

  AST_ADD_KEEPS:
  assert property (@(posedge core_clk) disable iff (rst)
    opAdd && !(apbAccess && pwrite) |=> $stable(flagsOut) &&
      constSum == 16'($past(opReq.firstAccumulator) +
                      $past(opReq.constValue)))
    else $error("constant add disturbed flags or sum");

  // checked one cycle on, so a flag write in the previous cycle is not blamed
  AST_IDLE_HOLD:
  assert property (@(posedge core_clk) disable iff (rst)
    !opValid && !(apbAccess && pwrite) |=> $stable(flagsOut))
    else $error("flags moved without an operation");

  AST_CMP_GREATER:
  assert property (@(posedge core_clk) disable iff (rst)
    opCmp && $signed(opReq.secondAccumulator) >
             $signed(opReq.firstAccumulator) |=>
      flagsOut.statusCodeHigh && !flagsOut.statusCodeLow &&
      jumpsOut.jumpOnPlus)
    else $error("compare greater-than codes wrong");

  AST_LOGIC_KEEPS_OVF:
  assert property (@(posedge core_clk) disable iff (rst)
    opLogic && !(apbAccess && pwrite) |=>
      $stable(flagsOut.overflowCode))
    else $error("word logic changed overflow code");

  AST_LOGIC_CODES:
  assert property (@(posedge core_clk) disable iff (rst)
    opLogic |=>
      {flagsOut.statusCodeHigh, flagsOut.statusCodeLow} ==
        {$past(opReq.logicResult) != 16'h0000, 1'b0})
    else $error("word logic status codes wrong");

  AST_SHIFT_KEEPS_OVF:
  assert property (@(posedge core_clk) disable iff (rst)
    opShift && !(apbAccess && pwrite) |=>
      $stable(flagsOut.overflowCode))
    else $error("shift changed overflow code");

  AST_SHIFT_CODES:
  assert property (@(posedge core_clk) disable iff (rst)
    opShift |=>
      {flagsOut.statusCodeHigh, flagsOut.statusCodeLow} ==
        {$past(opReq.shiftOutBit), 1'b0})
    else $error("shift status codes wrong");

  AST_RESET_CLEAR:
  assert property (@(posedge core_clk) $past(rst) |-> flagsOut == '0)
    else $error("flags not cleared by reset");

endmodule // condition_code_generator

/* tb/exec_datapath_model.sv */
// behavioural model of the execution datapath feeding the generator
`timescale 1ns/1ps
module exec_datapath_model (
  input  wire logic                  issue,
  input  wire cc_gen_pkg::op_class_t kind,
  input  wire cc_gen_pkg::cmp_rel_t  rel,
  input  wire logic [15:0]           accA,
  input  wire logic [15:0]           accB,
  input  wire logic                  lastBit,
  output logic                       opValid,
  output cc_gen_pkg::op_req_t        opReq
);
  // full-precision sum so every overflow range can reach the block
  always_comb begin
    opValid = issue;
    opReq.opClass = kind;
    opReq.cmpRel = rel;
    opReq.firstAccumulator = accA;
    opReq.secondAccumulator = accB;
    opReq.arithResult = $signed({{2{accA[15]}}, accA})
                      + $signed({{2{accB[15]}}, accB});
    opReq.logicResult = accA & accB;
    opReq.shiftOutBit = lastBit;
    opReq.constValue = accB;
  end
endmodule // exec_datapath_model

/* tb/condition_code_generator_bench.sv */
// self-checking bench for the condition-code generator
`timescale 1ns/1ps
module condition_code_generator_bench;
  logic                  core_clk;
  logic                  rst;
  logic                  issue;
  cc_gen_pkg::op_class_t kind;
  cc_gen_pkg::op_class_t curKind;
  cc_gen_pkg::cmp_rel_t  rel;
  cc_gen_pkg::cmp_rel_t  curRel;
  logic [15:0]           accA;
  logic [15:0]           accB;
  logic                  lastBit;
  logic                  opValid;
  cc_gen_pkg::op_req_t   opReq;
  cc_gen_pkg::flags_t    flagsOut;
  cc_gen_pkg::jumps_t    jumpsOut;
  logic [15:0]           constSum;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [31:0]           rd;
  logic                  err;
  int                    n_mismatch;
  int                    compares;

  exec_datapath_model i_model (.issue(issue), .kind(kind), .rel(rel),
    .accA(accA), .accB(accB), .lastBit(lastBit), .opValid(opValid),
    .opReq(opReq));
  condition_code_generator i_dut (.core_clk(core_clk), .rst(rst),
    .opValid(opValid), .opReq(opReq), .flagsOut(flagsOut),
    .jumpsOut(jumpsOut), .constSum(constSum), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h not %h", $time, what, got, exp);
    end
  endtask

  // jump decode derived from the {logic bit, ovf, high, low} pattern
  function automatic logic [5:0] expj(input logic [3:0] e);
    return {e[1:0] == 2'b00, e[1:0] != 2'b00, e[1:0] == 2'b10,
            e[1:0] == 2'b01, e[2], e[3]};
  endfunction

  task automatic look(input logic [3:0] e);
    chk({28'h0, flagsOut}, {28'h0, e}, "flags");
    chk({26'h0, jumpsOut}, {26'h0, expj(e)}, "jumps");
  endtask

  task automatic run(input logic [15:0] a, input logic [15:0] b,
                     input logic s, input logic [3:0] e);
    @(posedge core_clk);
    issue <= 1'b1;
    kind <= curKind;
    rel <= curRel;
    accA <= a;
    accB <= b;
    lastBit <= s;
    @(posedge core_clk);
    issue <= 1'b0;
    #10;
    look(e);
  endtask

  // waits on pready for up to 20 cycles; no fixed slave latency is assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("wrong value at %0t: no pready", $time);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #10;
  endtask

  initial begin
    n_mismatch = 0;
    compares = 0;
    rst = 1'b1;
    issue = 1'b0;
    kind = cc_gen_pkg::OP_NONE;
    curRel = cc_gen_pkg::REL_EQ;
    rel = cc_gen_pkg::REL_EQ;
    accA = 16'h0000;
    accB = 16'h0000;
    lastBit = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #10;
    look(4'h0);
    apb(1'b0, cc_gen_pkg::OFFS_SUM, 32'h0);
    chk(rd, 32'h0, "sum after reset");
    $display("test reset done");
    curKind = cc_gen_pkg::OP_ARITH;
    run(16'h8000, 16'hffff, 1'b0, 4'h6);
    run(16'hffff, 16'h0000, 1'b0, 4'h1);
    run(16'h0000, 16'h0000, 1'b0, 4'h0);
    run(16'h0001, 16'h0000, 1'b0, 4'h2);
    run(16'h7fff, 16'h7fff, 1'b0, 4'h5);
    run(16'h8000, 16'h8000, 1'b0, 4'h4);
    $display("test arithmetic done");
    curKind = cc_gen_pkg::OP_COMPARE;
    run(16'h0005, 16'h0005, 1'b0, 4'hc);
    curRel = cc_gen_pkg::REL_GT;
    run(16'h0005, 16'h0003, 1'b0, 4'h5);
    curRel = cc_gen_pkg::REL_GE;
    run(16'hfffe, 16'h0003, 1'b0, 4'he);
    curRel = cc_gen_pkg::REL_NE;
    run(16'h0007, 16'h0007, 1'b0, 4'h4);
    curRel = cc_gen_pkg::REL_LT;
    run(16'h0001, 16'h8000, 1'b0, 4'hd);
    curRel = cc_gen_pkg::REL_LE;
    run(16'h8000, 16'h7fff, 1'b0, 4'h6);
    run(16'h0003, 16'h0003, 1'b0, 4'hc);
    $display("test compare done");
    curKind = cc_gen_pkg::OP_LOGIC;
    run(16'hf0f0, 16'h0f0f, 1'b0, 4'hc);
    run(16'h00ff, 16'h0180, 1'b0, 4'he);
    curKind = cc_gen_pkg::OP_SHIFT;
    run(16'h0000, 16'h0000, 1'b0, 4'hc);
    run(16'h0000, 16'h0000, 1'b1, 4'he);
    $display("test logic and shift done");
    curKind = cc_gen_pkg::OP_CONVERT;
    run(16'h8000, 16'h0000, 1'b0, 4'hd);
    run(16'h0001, 16'h0000, 1'b0, 4'h9);
    run(16'h0000, 16'h0000, 1'b0, 4'h8);
    run(16'hfffb, 16'h0000, 1'b0, 4'ha);
    $display("test conversion done");
    curKind = cc_gen_pkg::OP_CONSTADD;
    run(16'hffff, 16'h0002, 1'b1, 4'ha);
    chk({16'h0, constSum}, 32'h1, "sum port");
    curKind = cc_gen_pkg::OP_NONE;
    run(16'h0000, 16'h0000, 1'b1, 4'ha);
    apb(1'b1, cc_gen_pkg::OFFS_SUM, 32'hffff);
    apb(1'b0, cc_gen_pkg::OFFS_SUM, 32'h0);
    chk(rd, 32'h1, "sum register");
    $display("test constant add done");
    apb(1'b1, cc_gen_pkg::OFFS_FLAGS, 32'h5);
    look(4'h5);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'h0c, 32'hf);
    apb(1'b0, cc_gen_pkg::OFFS_FLAGS, 32'h0);
    chk(rd, 32'h5, "flag register");
    chk({31'h0, err}, 32'h0, "flag read error");
    $display("test register access done");
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #10;
    look(4'h0);
    apb(1'b0, cc_gen_pkg::OFFS_SUM, 32'h0);
    chk(rd, 32'h0, "sum after second reset");
    $display("test second reset done");
    close_out();
  end
endmodule // condition_code_generator_bench
